//--- hw/gts_pkg.sv
// constants for the gated sixteen-bit timer: register map, fields, reset values
// assumes a classic wishbone master with 32-bit data and byte-sized registers
//
// Overview of operation
// - counter byte reads return the registered count one byte at a time; the pair is not latched together.
// - gated and gate active: count on timer tick; gate inactive: hold count.
// - polarity 0 counts while gate low, polarity 1 counts while gate high.
// - gate source 00 pin, 01 eight-bit overflow, 10 comparator 1, 11 comparator 2.
// - eight-bit timer wrap from FF to 00 makes a gate pulse.
// - each comparator gate source optionally synchronised, else passed straight through.
// - toggle mode flips a flip-flop on each rising gate edge; off clears it.
// - single pulse: go arms, next rising edge counts, trailing edge clears go.
// - toggle and single pulse together measure one full gate period.
// - gate level status always shows gate level, even with gating disabled.
// - falling gate level sets gate event flag; enable allows interrupt request.
// - gate event flag keeps working while gated counting is disabled.
// - counter wraps FFFF to 0000 and sets the overflow flag.
// - counting in sleep only in async counter mode; overflow then wakes.
// - secondary oscillator keeps running in sleep regardless of sync bit.
// - capture copies counter into capture pair; compare equality raises event.
// - auto-conversion trigger clears counter without setting overflow flag.
// - counter byte write wins over a coincident trigger clear.
// - clearing timer on stops counting and clears toggle flip-flop.
package gts_pkg;

  // register byte addresses
  localparam logic [7:0] ADR_TCTRL = 8'h00;
  localparam logic [7:0] ADR_GCTRL = 8'h04;
  localparam logic [7:0] ADR_CNTL = 8'h08;
  localparam logic [7:0] ADR_CNTH = 8'h0C;
  localparam logic [7:0] ADR_CCPL = 8'h10;
  localparam logic [7:0] ADR_CCPH = 8'h14;
  localparam logic [7:0] ADR_FLAG = 8'h18;
  localparam logic [7:0] ADR_IEN = 8'h1C;
  localparam logic [7:0] ADR_ICTL = 8'h20;
  localparam logic [7:0] ADR_CCPCTL = 8'h24;

  // timer control fields
  localparam int unsigned TC_ON = 0;
  localparam int unsigned TC_SYNC_BYP = 2;
  localparam int unsigned TC_OSC_EN = 3;
  localparam int unsigned TC_CS_LO = 6;
  localparam logic [7:0] TC_WMASK = 8'hFD;

  // gate control fields
  localparam int unsigned GC_SS_LO = 0;
  localparam int unsigned GC_VAL = 2;
  localparam int unsigned GC_GO = 3;
  localparam int unsigned GC_SPM = 4;
  localparam int unsigned GC_TM = 5;
  localparam int unsigned GC_POL = 6;
  localparam int unsigned GC_GE = 7;
  localparam logic [7:0] GC_WMASK = 8'hF3;

  // flag, enable and interrupt control fields
  localparam int unsigned FL_OVF = 0;
  localparam int unsigned FL_GATE = 7;
  localparam int unsigned IC_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int unsigned IC_GIE = 7;

  // capture/compare control fields
  localparam int unsigned CC_CAPTURE = 0;
  localparam int unsigned CC_AUTO_TRIG = 1;
  localparam int unsigned CC_C1_SYNC = 2;
  localparam int unsigned CC_C2_SYNC = 3;
  localparam logic [7:0] CC_WMASK = 8'h0F;

  // codes and values
  localparam logic [1:0] CS_EXTERNAL = 2'b10;
  localparam logic [1:0] GSS_PIN = 2'h0;
  localparam logic [1:0] GSS_OVF8 = 2'h1;
  localparam logic [1:0] GSS_CMP1 = 2'h2;
  localparam logic [1:0] GSS_CMP2 = 2'h3;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // single-pulse acquisition states
  typedef enum logic [2:0] {
    SP_IDLE = 3'b001,
    SP_ARMED = 3'b010,
    SP_RUN = 3'b100
  } gts_sp_e;

endpackage

//--- hw/gts_timer.sv
// gated sixteen-bit timer: gate logic, counter, flags and capture/compare time base
// assumes sys_clk is the timer clock domain; count_tick marks each selected timer clock
// edge and all inputs are synchronous to sys_clk
`timescale 1ns/10ps
module gts_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // timer clock and power state
  input wire logic count_tick,
  input wire logic sleep_mode,
  // gate sources
  input wire logic gate_input_pin,
  input wire logic [7:0] eight_bit_count,
  input wire logic comparator_one_gate_out,
  input wire logic comparator_two_gate_out,
  // capture/compare unit
  input wire logic capture_event,
  output logic compare_event,
  output logic conversion_trigger,
  // system requests
  output logic irq_request,
  output logic wake_request,
  output logic secondary_osc_run
);

  // bus decode
  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] rd_data;
  wire req = wb_cyc_i & wb_stb_i;
  // a write lands on the edge that sees ack high, never earlier
  wire wr = req & wb_we_i & ack_r & wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];
  wire wr_tctrl = wr && (wb_adr_i == gts_pkg::ADR_TCTRL);
  wire wr_gctrl = wr && (wb_adr_i == gts_pkg::ADR_GCTRL);
  wire wr_cntl = wr && (wb_adr_i == gts_pkg::ADR_CNTL);
  wire wr_cnth = wr && (wb_adr_i == gts_pkg::ADR_CNTH);
  wire wr_ccpl = wr && (wb_adr_i == gts_pkg::ADR_CCPL);
  wire wr_ccph = wr && (wb_adr_i == gts_pkg::ADR_CCPH);
  wire wr_flag = wr && (wb_adr_i == gts_pkg::ADR_FLAG);
  wire wr_ien = wr && (wb_adr_i == gts_pkg::ADR_IEN);
  wire wr_ictl = wr && (wb_adr_i == gts_pkg::ADR_ICTL);
  wire wr_ccpctl = wr && (wb_adr_i == gts_pkg::ADR_CCPCTL);

  // software registers
  logic [7:0] tctrl_r;
  logic [7:0] gctrl_r;
  logic [7:0] ien_r;
  logic [7:0] ictl_r;
  logic [7:0] ccpctl_r;
  logic go_r;
  logic go_nxt;
  logic gval_r;
  logic ovf_flag_r;
  logic gate_flag_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] ccp_r;

  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  function automatic logic fall(input logic cur, input logic prev);
    return ~cur & prev;
  endfunction

  wire timer_on = tctrl_r[gts_pkg::TC_ON];
  wire sync_bypass = tctrl_r[gts_pkg::TC_SYNC_BYP];
  wire [1:0] clk_src = tctrl_r[gts_pkg::TC_CS_LO +: 2];
  wire gate_en = gctrl_r[gts_pkg::GC_GE];
  wire gate_pol = gctrl_r[gts_pkg::GC_POL];
  wire tog_en = gctrl_r[gts_pkg::GC_TM];
  wire sp_en = gctrl_r[gts_pkg::GC_SPM];
  wire [1:0] gate_sel = gctrl_r[gts_pkg::GC_SS_LO +: 2];

  // the byte is sampled, so the wrap pulse lags the wrap by a cycle
  // wrap pulse
  logic [7:0] t8_prev_r;
  logic t8_wrap_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      t8_prev_r <= gts_pkg::RST_BYTE;
      t8_wrap_r <= 1'b0;
    end else begin
      t8_prev_r <= eight_bit_count;
      t8_wrap_r <= (t8_prev_r == gts_pkg::BYTE_MAX) && (eight_bit_count == gts_pkg::BYTE_ZERO);
    end
  end

  // unsynced path saves a cycle but lets comparator glitches reach the gate
  // optional comparator sync
  logic c1_sync_r;
  logic c2_sync_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      c1_sync_r <= 1'b0;
      c2_sync_r <= 1'b0;
    end else begin
      c1_sync_r <= comparator_one_gate_out;
      c2_sync_r <= comparator_two_gate_out;
    end
  end
  wire c1_src = ccpctl_r[gts_pkg::CC_C1_SYNC] ? c1_sync_r : comparator_one_gate_out;
  wire c2_src = ccpctl_r[gts_pkg::CC_C2_SYNC] ? c2_sync_r : comparator_two_gate_out;

  logic gate_raw;
  always_comb begin
    unique case (gate_sel)
      gts_pkg::GSS_PIN: gate_raw = gate_input_pin;
      gts_pkg::GSS_OVF8: gate_raw = t8_wrap_r;
      gts_pkg::GSS_CMP1: gate_raw = c1_src;
      gts_pkg::GSS_CMP2: gate_raw = c2_src;
    endcase
  end

  wire gate_act = gate_pol ? gate_raw : ~gate_raw;

  // a polarity change in the same write can look like a rising edge
  // toggle flip-flop
  logic gact_prev_r;
  logic tog_r;
  wire tog_nxt = (~tog_en | ~timer_on) ? 1'b0 : (tog_r ^ rise(gate_act, gact_prev_r));
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gact_prev_r <= 1'b0;
      tog_r <= 1'b0;
    end else begin
      gact_prev_r <= gate_act;
      tog_r <= tog_nxt;
    end
  end
  wire tog_sig = tog_en ? tog_r : gate_act;

  // clearing go or the mode aborts a running acquisition
  // single-pulse acquisition
  gts_pkg::gts_sp_e sp_r;
  gts_pkg::gts_sp_e sp_nxt;
  logic tsig_prev_r;
  wire tsig_rise = rise(tog_sig, tsig_prev_r);
  wire tsig_fall = fall(tog_sig, tsig_prev_r);
  logic hw_go_clr;

  // arm, run on next edge, finish on trailing edge
  always_comb begin
    sp_nxt = sp_r;
    hw_go_clr = 1'b0;
    unique case (sp_r)
      gts_pkg::SP_IDLE: begin
        if (sp_en && go_r) begin
          sp_nxt = gts_pkg::SP_ARMED;
        end
      end
      gts_pkg::SP_ARMED: begin
        if (!sp_en || !go_r) begin
          sp_nxt = gts_pkg::SP_IDLE;
        end else if (tsig_rise) begin
          sp_nxt = gts_pkg::SP_RUN;
        end
      end
      gts_pkg::SP_RUN: begin
        if (!sp_en || !go_r) begin
          sp_nxt = gts_pkg::SP_IDLE;
        end else if (tsig_fall) begin
          sp_nxt = gts_pkg::SP_IDLE;
          hw_go_clr = 1'b1;
        end
      end
      default: sp_nxt = gts_pkg::SP_IDLE;
    endcase
  end

  // software setting go wins over the hardware clear
  always_comb begin
    go_nxt = go_r;
    if (wr_gctrl) begin
      go_nxt = wd[gts_pkg::GC_GO];
    end else if (hw_go_clr) begin
      go_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sp_r <= gts_pkg::SP_IDLE;
      tsig_prev_r <= 1'b0;
      go_r <= 1'b0;
    end else begin
      sp_r <= sp_nxt;
      tsig_prev_r <= tog_sig;
      go_r <= go_nxt;
    end
  end

  wire gval = sp_en ? (sp_r == gts_pkg::SP_RUN) : tog_sig;

  // count_tick arrives already prescaled and edge-selected from outside
  // counting
  // sleep counting only in async external mode
  wire run_ok = ~sleep_mode | (sync_bypass & (clk_src == gts_pkg::CS_EXTERNAL));
  // gate holds or lets the count run
  wire inc = timer_on & (~gate_en | gval) & count_tick & run_ok;
  wire cnt_wr = wr_cntl | wr_cnth;
  wire trig_clr = conversion_trigger;

  // write also beats a coincident increment
  always_comb begin
    cnt_nxt = cnt_r;
    if (cnt_wr) begin
      if (wr_cntl) begin
        cnt_nxt[7:0] = wd;
      end
      if (wr_cnth) begin
        cnt_nxt[15:8] = wd;
      end
    end else if (trig_clr) begin
      cnt_nxt = gts_pkg::RST_WORD;
    end else if (inc) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  wire ovf_set = inc & ~cnt_wr & ~trig_clr & (cnt_r == gts_pkg::COUNT_MAX);
  // falling gate value sets event flag
  wire gate_set = fall(gval, gval_r);

  // one pulse per match, even while the count dwells on the pair
  // compare match and capture
  wire capture_mode = ccpctl_r[gts_pkg::CC_CAPTURE];
  wire match = ~capture_mode & (cnt_r == ccp_r);
  logic match_prev_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_r <= gts_pkg::RST_WORD;
      ccp_r <= gts_pkg::RST_WORD;
      gval_r <= 1'b0;
      match_prev_r <= 1'b0;
      compare_event <= 1'b0;
      conversion_trigger <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      gval_r <= gval;
      match_prev_r <= match;
      compare_event <= rise(match, match_prev_r);
      conversion_trigger <= rise(match, match_prev_r) & ccpctl_r[gts_pkg::CC_AUTO_TRIG];
      if (wr_ccpl) begin
        ccp_r[7:0] <= wd;
      end else if (capture_mode && capture_event) begin
        ccp_r[7:0] <= cnt_r[7:0];
      end
      if (wr_ccph) begin
        ccp_r[15:8] <= wd;
      end else if (capture_mode && capture_event) begin
        ccp_r[15:8] <= cnt_r[15:8];
      end
    end
  end

  // flags: a hardware set wins over a software clear in the same cycle
  wire ovf_flag_nxt = ovf_set | (wr_flag ? wd[gts_pkg::FL_OVF] : ovf_flag_r);
  wire gate_flag_nxt = gate_set | (wr_flag ? wd[gts_pkg::FL_GATE] : gate_flag_r);

  wire peripheral_irq_enable = ictl_r[gts_pkg::IC_PERIPHERAL_IRQ_ENABLE];
  wire global_irq_enable = ictl_r[gts_pkg::IC_GIE];
  wire pend = (gate_flag_r & ien_r[gts_pkg::FL_GATE]) | (ovf_flag_r & ien_r[gts_pkg::FL_OVF]);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tctrl_r <= gts_pkg::RST_BYTE;
      gctrl_r <= gts_pkg::RST_BYTE;
      ien_r <= gts_pkg::RST_BYTE;
      ictl_r <= gts_pkg::RST_BYTE;
      ccpctl_r <= gts_pkg::RST_BYTE;
      ovf_flag_r <= 1'b0;
      gate_flag_r <= 1'b0;
      irq_request <= 1'b0;
      wake_request <= 1'b0;
      secondary_osc_run <= 1'b0;
    end else begin
      // gate configuration held in timer-domain registers
      if (wr_tctrl) begin
        tctrl_r <= wd & gts_pkg::TC_WMASK;
      end
      if (wr_gctrl) begin
        gctrl_r <= wd & gts_pkg::GC_WMASK;
      end
      if (wr_ien) begin
        ien_r <= wd;
      end
      if (wr_ictl) begin
        ictl_r <= wd;
      end
      if (wr_ccpctl) begin
        ccpctl_r <= wd & gts_pkg::CC_WMASK;
      end
      ovf_flag_r <= ovf_flag_nxt;
      gate_flag_r <= gate_flag_nxt;
      irq_request <= global_irq_enable & peripheral_irq_enable & pend;
      // wake does not need the global enable
      wake_request <= sleep_mode & peripheral_irq_enable & ovf_flag_r & ien_r[gts_pkg::FL_OVF];
      secondary_osc_run <= tctrl_r[gts_pkg::TC_OSC_EN];
    end
  end

  // count bytes are not latched as a pair; a carry between two reads shows
  // read mux; unmapped addresses read zero
  // count bytes come from the registered counter
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      gts_pkg::ADR_TCTRL: rd_data[7:0] = tctrl_r;
      gts_pkg::ADR_GCTRL: begin
        rd_data[7:0] = gctrl_r;
        rd_data[gts_pkg::GC_GO] = go_r;
        rd_data[gts_pkg::GC_VAL] = gval_r;
      end
      gts_pkg::ADR_CNTL: rd_data[7:0] = cnt_r[7:0];
      gts_pkg::ADR_CNTH: rd_data[7:0] = cnt_r[15:8];
      gts_pkg::ADR_CCPL: rd_data[7:0] = ccp_r[7:0];
      gts_pkg::ADR_CCPH: rd_data[7:0] = ccp_r[15:8];
      gts_pkg::ADR_FLAG: begin
        rd_data[gts_pkg::FL_OVF] = ovf_flag_r;
        rd_data[gts_pkg::FL_GATE] = gate_flag_r;
      end
      gts_pkg::ADR_IEN: rd_data[7:0] = ien_r;
      gts_pkg::ADR_ICTL: rd_data[7:0] = ictl_r;
      gts_pkg::ADR_CCPCTL: rd_data[7:0] = ccpctl_r;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // one-cycle ack; every address answers, so a stray access never hangs the master
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req && !ack_r) begin
        dat_r <= rd_data;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

endmodule // gts_timer

//--- tb/gts_timer_sva.sv
// checker on the timer ports: bus handshake, event pulses, sleep outputs
// assumes one clock domain, sys_clk, with synchronous sys_rst
`timescale 1ns/10ps
module gts_timer_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // power and events
  input wire logic sleep_mode,
  input wire logic compare_event,
  input wire logic conversion_trigger,
  input wire logic wake_request,
  input wire logic secondary_osc_run
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  wire req = wb_cyc_i & wb_stb_i;
  wire rd_ack = wb_ack_o & ~wb_we_i;
  wire osc_wr = req & wb_ack_o & wb_we_i & wb_sel_i[0] & (wb_adr_i == gts_pkg::ADR_TCTRL);
  a_ack_next: assert property (req & ~wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req))
    else $error("ack without request");
  a_read_upper: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_read_hole: assert property (rd_ack & (wb_adr_i > gts_pkg::ADR_CCPCTL) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_trig_compare: assert property (conversion_trigger |-> compare_event)
    else $error("trigger without compare");
  a_compare_once: assert property (compare_event |=> !compare_event)
    else $error("compare event repeated");
  a_wake_sleep: assert property (wake_request |-> $past(sleep_mode))
    else $error("wake while awake");
  a_osc_follow: assert property (osc_wr |=> ##1 secondary_osc_run == $past(wb_dat_i[3], 2))
    else $error("oscillator run mismatch");
endmodule // gts_timer_sva
bind gts_timer gts_timer_sva u_sva (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .sleep_mode, .compare_event,
  .conversion_trigger, .wake_request, .secondary_osc_run);

//--- tb/gts_far_model.sv
// far side: eight-bit timer, two comparators, timer clock edges
// assumes the bench loads tick bursts and comparator levels on sys_clk
`timescale 1ns/10ps
module gts_far_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // bench control
  input wire logic burst_ld,
  input wire logic [7:0] burst_n,
  input wire logic [1:0] cmp_lvl,
  output logic burst_busy,
  // towards the timer
  output logic count_tick,
  output logic [7:0] eight_bit_count,
  output logic comparator_one_gate_out,
  output logic comparator_two_gate_out
);
  logic [7:0] left_r;
  // every other cycle, so each tick is a distinct edge
  wire fire = (left_r != 8'h00) & ~count_tick;
  assign burst_busy = (left_r != 8'h00) | count_tick;
  assign comparator_one_gate_out = cmp_lvl[0];
  assign comparator_two_gate_out = cmp_lvl[1];
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      left_r <= 8'h00;
      count_tick <= 1'b0;
      eight_bit_count <= 8'h00;
    end else begin
      left_r <= burst_ld ? burst_n : left_r - {7'h00, fire};
      count_tick <= fire;
      // free byte wraps FF to 00
      eight_bit_count <= eight_bit_count + 8'h01;
    end
  end
endmodule // gts_far_model

//--- tb/gts_timer_tb.sv
// self-checking bench for the gated sixteen-bit timer
// assumes gts_timer, the far-side model and the bound checker
`timescale 1ns/10ps
`define CHK(a, x) begin n_tests++; if ((a) !== (x)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (x)); end end
module gts_timer_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0, we = 1'b0, sleep = 1'b0, pin = 1'b0, cap = 1'b0, ld = 1'b0;
  logic [7:0] adr = 8'h00, bn = 8'h00, wd = 8'h00, e8;
  logic [1:0] cl = 2'h0, s;
  logic [31:0] rdat, lfsr = 32'h770E0354;
  logic [15:0] e;
  logic ack, tick, c1, c2, cmp_ev, trig, irq, wake, osc, busy;
  int err_total = 0, n_tests = 0, cyc_n = 0;
  int n_cmp = 0, n_trg = 0, cmp_base = 0, trg_base = 0;
  always #12.5 sys_clk = ~sys_clk;
  gts_far_model u_far (.sys_clk, .sys_rst, .burst_ld(ld), .burst_n(bn), .cmp_lvl(cl),
    .burst_busy(busy), .count_tick(tick), .eight_bit_count(e8),
    .comparator_one_gate_out(c1), .comparator_two_gate_out(c2));
  gts_timer u_dut (.sys_clk, .sys_rst, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i({24'h000000, wd}), .wb_ack_o(ack),
    .wb_dat_o(rdat), .count_tick(tick), .sleep_mode(sleep), .gate_input_pin(pin),
    .eight_bit_count(e8), .comparator_one_gate_out(c1), .comparator_two_gate_out(c2),
    .capture_event(cap), .compare_event(cmp_ev), .conversion_trigger(trig),
    .irq_request(irq), .wake_request(wake), .secondary_osc_run(osc));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic gate_on(input logic l, p);
    return l == p;
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge sys_clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, x, m);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(q & m, x)
  endtask
  task automatic cnt(input logic [15:0] x);
    rc(gts_pkg::ADR_CNTL, x[7:0], 8'hFF);
    rc(gts_pkg::ADR_CNTH, x[15:8], 8'hFF);
  endtask
  task automatic setc(input logic [15:0] v);
    wr(gts_pkg::ADR_TCTRL, 8'h00);
    wr(gts_pkg::ADR_CNTL, v[7:0]);
    wr(gts_pkg::ADR_CNTH, v[15:8]);
  endtask
  task automatic ticks(input logic [7:0] n);
    @(posedge sys_clk);
    ld <= 1'b1;
    bn <= n;
    @(posedge sys_clk);
    ld <= 1'b0;
    do @(posedge sys_clk); while (busy);
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic wrap_up;
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // far above the roughly 1500 cycles needed
  always @(posedge sys_clk) begin
    cyc_n++;
    if (cmp_ev === 1'b1) n_cmp++;
    if (trig === 1'b1) n_trg++;
    if (cyc_n == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // gate level bit is live; 8'h28 is a hole
    for (int i = 0; i <= 10; i++) rc(8'(i * 4), 8'h00, 8'hFB);
    repeat (8) begin
      lfsr = nxt(lfsr);
      setc(lfsr[15:0]);
      cnt(lfsr[15:0]);
    end
    setc(16'h0000);
    wr(gts_pkg::ADR_TCTRL, 8'h01);
    wr(gts_pkg::ADR_CCPCTL, 8'h0C);
    e = 16'h0000;
    // only the selected source carries the test level
    for (int k = 0; k < 12; k++) begin
      s = (k < 4) ? 2'h0 : {1'b1, k[3]};
      pin <= k[0] ^ (s != 2'h0);
      cl <= {k[0] ^ (s != 2'h3), k[0] ^ (s != 2'h2)};
      wr(gts_pkg::ADR_GCTRL, {1'b1, k[1], 4'h0, s});
      rc(gts_pkg::ADR_GCTRL, {5'h00, gate_on(k[0], k[1]), 2'h0}, 8'h04);
      ticks(8'h05);
      if (gate_on(k[0], k[1])) e = e + 16'h0005;
      cnt(e);
    end
    wr(gts_pkg::ADR_GCTRL, 8'h40);
    pin <= 1'b1;
    ticks(8'h03);
    rc(gts_pkg::ADR_GCTRL, 8'h04, 8'h04);
    cnt(e + 16'h0003);
    setc(16'hFFFE);
    wr(gts_pkg::ADR_FLAG, 8'h00);
    wr(gts_pkg::ADR_IEN, 8'h01);
    wr(gts_pkg::ADR_ICTL, 8'hC0);
    wr(gts_pkg::ADR_TCTRL, 8'h01);
    ticks(8'h03);
    cnt(16'h0001);
    rc(gts_pkg::ADR_FLAG, 8'h01, 8'h01);
    `CHK(irq, 1'b1)
    wr(gts_pkg::ADR_FLAG, 8'h00);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    setc(16'hFFFF);
    wr(gts_pkg::ADR_FLAG, 8'h00);
    sleep <= 1'b1;
    wr(gts_pkg::ADR_TCTRL, 8'h8D);
    ticks(8'h01);
    `CHK(wake, 1'b1)
    wr(gts_pkg::ADR_TCTRL, 8'h89);
    ticks(8'h02);
    cnt(16'h0000);
    `CHK(osc, 1'b1)
    sleep <= 1'b0;
    lfsr = nxt(lfsr);
    setc(lfsr[15:0]);
    wr(gts_pkg::ADR_CCPCTL, 8'h01);
    cap <= 1'b1;
    @(posedge sys_clk);
    cap <= 1'b0;
    rc(gts_pkg::ADR_CCPL, lfsr[7:0], 8'hFF);
    rc(gts_pkg::ADR_CCPH, lfsr[15:8], 8'hFF);
    wr(gts_pkg::ADR_CCPCTL, 8'h02);
    wr(gts_pkg::ADR_CCPL, 8'h05);
    wr(gts_pkg::ADR_CCPH, 8'h00);
    setc(16'h0000);
    wr(gts_pkg::ADR_FLAG, 8'h00);
    wr(gts_pkg::ADR_TCTRL, 8'h01);
    cmp_base = n_cmp;
    trg_base = n_trg;
    ticks(8'h05);
    cnt(16'h0000);
    `CHK(n_cmp - cmp_base, 1)
    `CHK(n_trg - trg_base, 1)
    rc(gts_pkg::ADR_FLAG, 8'h00, 8'h01);
    wr(gts_pkg::ADR_CCPCTL, 8'h00);
    setc(16'h0000);
    pin <= 1'b0;
    wr(gts_pkg::ADR_TCTRL, 8'h01);
    wr(gts_pkg::ADR_GCTRL, 8'hD0);
    wr(gts_pkg::ADR_GCTRL, 8'hD8);
    ticks(8'h04);
    cnt(16'h0000);
    pin <= 1'b1;
    ticks(8'h04);
    cnt(16'h0004);
    pin <= 1'b0;
    ticks(8'h01);
    rc(gts_pkg::ADR_GCTRL, 8'h00, 8'h08);
    pin <= 1'b1;
    ticks(8'h04);
    cnt(16'h0004);
    pin <= 1'b0;
    wr(gts_pkg::ADR_GCTRL, 8'hF0);
    wr(gts_pkg::ADR_GCTRL, 8'hF8);
    for (int k = 0; k < 3; k++) begin
      pin <= ~k[0];
      ticks(8'h03);
    end
    cnt(16'h000A);
    rc(gts_pkg::ADR_GCTRL, 8'h00, 8'h08);
    wr(gts_pkg::ADR_GCTRL, 8'h40);
    wr(gts_pkg::ADR_TCTRL, 8'h00);
    ticks(8'h03);
    cnt(16'h000A);
    wr(gts_pkg::ADR_GCTRL, 8'h41);
    wr(gts_pkg::ADR_FLAG, 8'h00);
    wr(gts_pkg::ADR_IEN, 8'h80);
    repeat (300) @(posedge sys_clk);
    rc(gts_pkg::ADR_FLAG, 8'h80, 8'h80);
    `CHK(irq, 1'b1)
    wr(gts_pkg::ADR_GCTRL, 8'h40);
    wr(gts_pkg::ADR_FLAG, 8'h00);
    repeat (300) @(posedge sys_clk);
    rc(gts_pkg::ADR_FLAG, 8'h00, 8'h80);
    wrap_up();
  end
endmodule // gts_timer_tb
